/* mbt_exec_unit.sv */
// execution unit for branch, call, return, timer, a/d and port instructions
`timescale 1ns/1ps
`default_nettype none
`include "mbt_params.svh"
module mbt_exec_unit #(
	parameter logic [127:0] SEG_TABLE = 128'h71795e39_7c776f7f_077d6d66_4f5b063f
) (
	// clock, reset and enable
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// program memory
	output logic      [10:0] progAddr,
	input  wire logic [8:0]  instrWord,
	// working registers held outside
	input  wire logic [3:0]  accIn,
	input  wire logic [3:0]  bIn,
	input  wire logic [3:0]  yIn,
	input  wire logic [7:0]  wideIn,
	output logic             accWrEn,
	output logic      [3:0]  accWrData,
	output logic             bWrEn,
	output logic      [3:0]  bWrData,
	// a/d converter
	input  wire logic [7:0]  adResult,
	output logic             adStop,
	// timers
	input  wire logic [7:0]  timerOneIn,
	input  wire logic [7:0]  timerTwoIn,
	input  wire logic        timerOneFlag,
	input  wire logic        timerTwoFlag,
	output logic             timerOneLoad,
	output logic      [7:0]  timerOneData,
	output logic      [7:0]  reloadValue,
	output logic      [3:0]  timerCtlV,
	output logic      [3:0]  timerCtlW,
	// interrupt entry
	input  wire logic        intRequest,
	input  wire logic [10:0] intVector,
	output logic             irqAllowFlag,
	// ports
	output logic      [11:0] digitOut,
	output logic      [7:0]  segOut,
	output logic      [3:0]  fOut,
	input  wire logic [7:0]  segPins,
	input  wire logic [3:0]  fPins,
	// axi4-lite slave
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic      [1:0]  s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic      [31:0] s_axi_rdata,
	output logic      [1:0]  s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	mbt_pkg::mbt_state_t stQ, stD;
	logic [10:0] pcQ, pcD, pcInc, pushData;
	logic [10:0] stackQ [3];
	logic [3:0]  pageQ, pageD;
	logic        idxQ, idxD;
	logic        p2Q, p2SavedQ, skipQ, runQ;
	logic        push, pop, p2Set, p2Clr, p2Rest, skipSet, done, intTake;
	logic        run, fire, isOp;
	logic [7:0]  segSync1, segSync2;
	logic [3:0]  fSync1, fSync2;
	logic        awHeldQ, wHeldQ;
	logic [3:0]  awAddrQ;
	logic [31:0] wDataQ;
	logic [3:0]  wStrbQ;
	logic [31:0] rdData;
	logic        rdHit;

	assign progAddr = pcQ;
	assign pcInc    = {pcQ[10:7], 7'(pcQ[6:0] + 7'h01)};
	assign run      = ce & runQ;
	assign intTake  = run & intRequest & irqAllowFlag & (stQ == mbt_pkg::MBT_ST_FIRST) & ~skipQ;
	// single-word effects fire only on a live, unskipped first word
	assign fire     = run & (stQ == mbt_pkg::MBT_ST_FIRST) & ~skipQ & ~intTake;

	// sequencing of jumps, calls, returns and skips
	always_comb begin
		stD = mbt_pkg::MBT_ST_FIRST;
		pcD = pcInc;
		pushData = pcInc;
		pageD = pageQ;
		idxD = idxQ;
		push = 1'b0;
		pop = 1'b0;
		p2Set = 1'b0;
		p2Clr = 1'b0;
		p2Rest = 1'b0;
		skipSet = 1'b0;
		done = 1'b1;
		isOp = 1'b0;
		unique case (stQ)
			mbt_pkg::MBT_ST_FIRST: begin
				if (instrWord == `MBT_OP_INDEX) begin
					stD = mbt_pkg::MBT_ST_WORD2;
					idxD = 1'b1;
					done = 1'b0;
				end else if (instrWord[8:4] == `MBT_OP_LONG_HI) begin
					stD = mbt_pkg::MBT_ST_WORD2;
					idxD = 1'b0;
					pageD = instrWord[3:0];
					done = 1'b0;
				end else if (instrWord[8:7] == 2'b11) begin
					// in-page jump, page three in routine
					pcD = {p2Q ? `MBT_PAGE_SUB : pcQ[10:7], instrWord[6:0]};
				end else if (instrWord[8:7] == 2'b10) begin
					// short call, or plain jump in routine
					pcD = {`MBT_PAGE_CALL, instrWord[6:0]};
					push = ~p2Q;
					p2Set = 1'b1;
				end else if (instrWord == `MBT_OP_RET || instrWord == `MBT_OP_RET_SKIP) begin
					pcD = stackQ[0];
					pop = 1'b1;
					p2Clr = 1'b1;
					skipSet = instrWord[0];
				end else if (instrWord == `MBT_OP_IRET) begin
					pcD = stackQ[0];
					pop = 1'b1;
					p2Rest = 1'b1;
				end else begin
					isOp = 1'b1;
				end
			end
			mbt_pkg::MBT_ST_WORD2: begin
				if (idxQ && instrWord[8:4] == `MBT_OP_LONG_HI) begin
					stD = mbt_pkg::MBT_ST_WORD3;
					pageD = instrWord[3:0];
					done = 1'b0;
				end else if (idxQ && instrWord[7]) begin
					// indexed in-page jump, 16x plus A
					pcD = {p2Q ? `MBT_PAGE_SUB : pcQ[10:7], instrWord[6:4], accIn};
				end else if (idxQ) begin
					pcD = {`MBT_PAGE_CALL, instrWord[6:4], accIn};
					push = ~p2Q;
					p2Set = 1'b1;
				end else begin
					pcD = {pageQ, instrWord[6:0]};
					push = ~instrWord[7];
					p2Clr = 1'b1;
				end
			end
			mbt_pkg::MBT_ST_WORD3: begin
				pcD = {pageQ, instrWord[6:4], accIn};
				push = ~instrWord[7];
				p2Clr = 1'b1;
			end
			default: begin
				pcD = pcInc;
			end
		endcase
		if (stQ == mbt_pkg::MBT_ST_FIRST && isOp) begin
			unique case (instrWord)
				`MBT_OP_JBIT_SKIP: skipSet = ~adResult[yIn[2:0]];
				`MBT_OP_T1F_SKIP:  skipSet = timerOneFlag;
				`MBT_OP_T2F_SKIP:  skipSet = timerTwoFlag;
				`MBT_OP_DIG_SKIP:  skipSet = (yIn <= `MBT_DIG_LAST) & ~digitOut[yIn];
				default:           skipSet = 1'b0;
			endcase
		end
		// a skipped instruction walks its words with no effect
		if (skipQ) begin
			pcD = pcInc;
			push = 1'b0;
			pop = 1'b0;
			p2Set = 1'b0;
			p2Clr = 1'b0;
			p2Rest = 1'b0;
			skipSet = 1'b0;
		end
		// interrupt entry keeps the current address for re-fetch
		if (intTake) begin
			stD = mbt_pkg::MBT_ST_FIRST;
			pcD = intVector;
			pushData = pcQ;
			push = 1'b1;
			pop = 1'b0;
			p2Set = 1'b0;
			p2Clr = 1'b1;
			p2Rest = 1'b0;
			skipSet = 1'b0;
			done = 1'b1;
		end
	end

	// program counter, state and skip flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pcQ <= 11'h000;
			stQ <= mbt_pkg::MBT_ST_FIRST;
			pageQ <= 4'h0;
			idxQ <= 1'b0;
			skipQ <= 1'b0;
		end else if (run) begin
			pcQ <= pcD;
			stQ <= stD;
			pageQ <= pageD;
			idxQ <= idxD;
			if (done) begin
				skipQ <= skipSet;
			end
		end
	end

	// three-deep return stack, shifting on push and pop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				stackQ[i] <= 11'h000;
			end
		end else if (run && push) begin
			stackQ[2] <= stackQ[1];
			stackQ[1] <= stackQ[0];
			stackQ[0] <= pushData;
		end else if (run && pop) begin
			stackQ[0] <= stackQ[1];
			stackQ[1] <= stackQ[2];
		end
	end

	// page-two routine flag; saved copy restored by interrupt return
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			p2Q <= 1'b0;
			p2SavedQ <= 1'b0;
		end else if (run) begin
			if (intTake) begin
				p2SavedQ <= p2Q;
			end
			if (p2Rest) begin
				p2Q <= p2SavedQ;
			end else if (p2Clr) begin
				p2Q <= 1'b0;
			end else if (p2Set) begin
				p2Q <= 1'b1;
			end
		end
	end

	// pin inputs pass two flip-flops before any use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			segSync1 <= 8'h00;
			segSync2 <= 8'h00;
			fSync1 <= 4'h0;
			fSync2 <= 4'h0;
		end else if (ce) begin
			segSync1 <= segPins;
			segSync2 <= segSync1;
			fSync1 <= fPins;
			fSync2 <= fSync1;
		end
	end

	// accumulator and B write-back, one cycle after the instruction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			accWrEn <= 1'b0;
			accWrData <= 4'h0;
			bWrEn <= 1'b0;
			bWrData <= 4'h0;
		end else if (ce) begin
			accWrEn <= 1'b0;
			bWrEn <= 1'b0;
			if (fire) begin
				unique case (instrWord)
					// timer reads split into B and A
					`MBT_OP_T1_READ: begin
						{bWrData, accWrData} <= timerOneIn;
						{bWrEn, accWrEn} <= 2'b11;
					end
					`MBT_OP_RLD_READ: begin
						{bWrData, accWrData} <= reloadValue;
						{bWrEn, accWrEn} <= 2'b11;
					end
					`MBT_OP_T2_READ: begin
						{bWrData, accWrData} <= timerTwoIn;
						{bWrEn, accWrEn} <= 2'b11;
					end
					// operand picks upper or lower half
					`MBT_OP_SEG_RD_HI: begin
						accWrData <= segSync2[7:4];
						accWrEn <= 1'b1;
					end
					`MBT_OP_SEG_RD_LO: begin
						accWrData <= segSync2[3:0];
						accWrEn <= 1'b1;
					end
					`MBT_OP_F_RD: begin
						accWrData <= fSync2;
						accWrEn <= 1'b1;
					end
					default: begin
						accWrEn <= 1'b0;
					end
				endcase
			end
		end
	end

	// timers, a/d stop and interrupt-allow flag
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timerOneLoad <= 1'b0;
			timerOneData <= 8'h00;
			reloadValue <= 8'h00;
			timerCtlV <= 4'h0;
			timerCtlW <= 4'h0;
			adStop <= 1'b0;
			irqAllowFlag <= 1'b0;
		end else if (ce) begin
			// stop pulse only; result register is not touched
			adStop <= fire && instrWord == `MBT_OP_AD_END;
			// load timer one from B and A
			timerOneLoad <= fire && instrWord == `MBT_OP_T1_LOAD;
			if (fire && instrWord == `MBT_OP_T1_LOAD) begin
				timerOneData <= {bIn, accIn};
			end
			// load reload register from B and A
			if (fire && instrWord == `MBT_OP_RLD_LOAD) begin
				reloadValue <= {bIn, accIn};
			end
			// accumulator into control V or W
			if (fire && instrWord == `MBT_OP_CTLV_WR) begin
				timerCtlV <= accIn;
			end
			if (fire && instrWord == `MBT_OP_CTLW_WR) begin
				timerCtlW <= accIn;
			end
			// enable and disable; entry also disables
			if (intTake || (fire && instrWord == `MBT_OP_IRQ_DIS)) begin
				irqAllowFlag <= 1'b0;
			end else if (fire && instrWord == `MBT_OP_IRQ_EN) begin
				irqAllowFlag <= 1'b1;
			end
		end
	end

	// output ports
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			digitOut <= 12'h000;
			segOut <= 8'h00;
			fOut <= 4'h0;
		end else if (fire) begin
			unique case (instrWord)
				`MBT_OP_SEG_CLR:  segOut <= 8'h00;
				`MBT_OP_DIG_CLR:  digitOut <= 12'h000;
				`MBT_OP_BOTH_CLR: begin
					segOut <= 8'h00;
					digitOut <= 12'h000;
				end
				// Y above eleven leaves the port alone
				`MBT_OP_DIG_SET: begin
					if (yIn <= `MBT_DIG_LAST) digitOut[yIn] <= 1'b1;
				end
				`MBT_OP_DIG_RST: begin
					if (yIn <= `MBT_DIG_LAST) digitOut[yIn] <= 1'b0;
				end
				`MBT_OP_SEG_PAIR: segOut <= {bIn, accIn};
				`MBT_OP_SEG_WIDE: segOut <= wideIn;
				`MBT_OP_SEG_DEC:  segOut <= SEG_TABLE[{accIn, 3'b000} +: 8];
				`MBT_OP_F_WR:     fOut <= accIn;
				default:          fOut <= fOut;
			endcase
		end
	end

	// axi4-lite write: address and data taken in either order
	// readys drop with the enable so that no handshake is lost while frozen
	assign s_axi_awready = ce & ~awHeldQ & ~s_axi_bvalid;
	assign s_axi_wready  = ce & ~wHeldQ & ~s_axi_bvalid;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeldQ <= 1'b0;
			wHeldQ <= 1'b0;
			awAddrQ <= 4'h0;
			wDataQ <= 32'h0000_0000;
			wStrbQ <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MBT_RESP_OKAY;
			runQ <= `MBT_CTRL_RESET;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeldQ <= 1'b1;
				awAddrQ <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeldQ <= 1'b1;
				wDataQ <= s_axi_wdata;
				wStrbQ <= s_axi_wstrb;
			end
			if (awHeldQ && wHeldQ) begin
				awHeldQ <= 1'b0;
				wHeldQ <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// only the control word is writable
				if (awAddrQ == `MBT_REG_CTRL) begin
					s_axi_bresp <= `MBT_RESP_OKAY;
					if (wStrbQ[0]) runQ <= wDataQ[0];
				end else begin
					s_axi_bresp <= `MBT_RESP_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// axi4-lite read decode
	always_comb begin
		rdHit = 1'b1;
		unique case (s_axi_araddr)
			`MBT_REG_CTRL:   rdData = {31'h0, runQ};
			`MBT_REG_STATUS: rdData = {13'h0, skipQ, p2Q, irqAllowFlag, 5'h0, pcQ};
			`MBT_REG_TIMCTL: rdData = {16'h0, reloadValue, timerCtlW, timerCtlV};
			`MBT_REG_PORTS:  rdData = {fOut, segOut, 8'h0, digitOut};
			default: begin
				rdData = 32'h0000_0000;
				rdHit = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = ce & ~s_axi_rvalid;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `MBT_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdData;
				s_axi_rresp <= rdHit ? `MBT_RESP_OKAY : `MBT_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_jump_inpage: assert property (
		fire && instrWord[8:7] == 2'b11 && !p2Q |=> pcQ == {$past(pcQ[10:7]), $past(instrWord[6:0])}
	) else $error("in-page jump target wrong");
	chk_jump_page3: assert property (
		fire && instrWord[8:7] == 2'b11 && p2Q |=> pcQ[10:7] == `MBT_PAGE_SUB
	) else $error("routine jump not on page three");
	chk_call_push: assert property (
		fire && instrWord[8:7] == 2'b10 && !p2Q |=> stackQ[0] == $past(pcInc) && p2Q
	) else $error("call did not push return address");
	chk_routine_nopush: assert property (
		fire && instrWord[8:7] == 2'b10 && p2Q |=> $stable(stackQ[0]) && pcQ[10:7] == `MBT_PAGE_CALL
	) else $error("routine call pushed stack");
	chk_return_pop: assert property (
		fire && instrWord == `MBT_OP_RET_SKIP |=> pcQ == $past(stackQ[0]) && skipQ
	) else $error("skipping return wrong");
	chk_long_jump: assert property (
		run && stQ == mbt_pkg::MBT_ST_WORD2 && !idxQ && !skipQ && instrWord[7]
		|=> pcQ == {$past(pageQ), $past(instrWord[6:0])}
	) else $error("long jump target wrong");
	chk_timer_load: assert property (
		fire && instrWord == `MBT_OP_T1_LOAD |=> timerOneLoad && timerOneData == $past({bIn, accIn})
	) else $error("timer one load data wrong");
	chk_irq_allow: assert property (
		fire && instrWord == `MBT_OP_IRQ_EN |=> irqAllowFlag
	) else $error("enable did not set flag");
	chk_port_clear: assert property (
		fire && instrWord == `MBT_OP_BOTH_CLR |=> segOut == 8'h00 && digitOut == 12'h000
	) else $error("port clear failed");
	chk_skip_extent: assert property (
		run && skipQ && stQ == mbt_pkg::MBT_ST_FIRST && instrWord[8:7] == 2'b11
		|=> pcQ == $past(pcInc) && !skipQ
	) else $error("skip not one instruction");
	chk_iret_restore: assert property (
		fire && instrWord == `MBT_OP_IRET |=> pcQ == $past(stackQ[0]) && p2Q == $past(p2SavedQ)
	) else $error("interrupt return did not restore");

	cov_call_return: cover property (fire && instrWord[8:7] == 2'b10 ##[1:20] fire && instrWord == `MBT_OP_RET);
	cov_skip_taken: cover property (run && skipQ && stQ == mbt_pkg::MBT_ST_FIRST);
	cov_indexed_long: cover property (run && stQ == mbt_pkg::MBT_ST_WORD3 && !skipQ);
	cov_int_entry: cover property (intTake);
endmodule
`default_nettype wire

/* mbt_params.svh */
// constants of the branch, timer and port execution unit
`ifndef MBT_PARAMS_SVH
`define MBT_PARAMS_SVH
`define MBT_OP_AD_END     9'h050
`define MBT_OP_JBIT_SKIP  9'h029
`define MBT_OP_T1_LOAD    9'h084
`define MBT_OP_RLD_LOAD   9'h085
`define MBT_OP_T1_READ    9'h088
`define MBT_OP_RLD_READ   9'h089
`define MBT_OP_T2_READ    9'h08a
`define MBT_OP_CTLV_WR    9'h086
`define MBT_OP_CTLW_WR    9'h087
`define MBT_OP_T1F_SKIP   9'h082
`define MBT_OP_T2F_SKIP   9'h083
`define MBT_OP_INDEX      9'h001
`define MBT_OP_LONG_HI    5'h07
`define MBT_OP_IRET       9'h046
`define MBT_OP_RET        9'h044
`define MBT_OP_RET_SKIP   9'h045
`define MBT_OP_SEG_CLR    9'h010
`define MBT_OP_DIG_CLR    9'h013
`define MBT_OP_BOTH_CLR   9'h011
`define MBT_OP_DIG_SET    9'h015
`define MBT_OP_DIG_RST    9'h014
`define MBT_OP_DIG_SKIP   9'h02b
`define MBT_OP_SEG_PAIR   9'h01b
`define MBT_OP_SEG_DEC    9'h017
`define MBT_OP_SEG_WIDE   9'h00b
`define MBT_OP_SEG_RD_HI  9'h054
`define MBT_OP_SEG_RD_LO  9'h055
`define MBT_OP_F_WR       9'h081
`define MBT_OP_F_RD       9'h08c
`define MBT_OP_IRQ_EN     9'h005
`define MBT_OP_IRQ_DIS    9'h004
`define MBT_PAGE_CALL     4'h2
`define MBT_PAGE_SUB      4'h3
`define MBT_DIG_LAST      4'hb
`define MBT_REG_CTRL      4'h0
`define MBT_REG_STATUS    4'h4
`define MBT_REG_TIMCTL    4'h8
`define MBT_REG_PORTS     4'hc
`define MBT_CTRL_RESET    1'b1
`define MBT_RESP_OKAY     2'b00
`define MBT_RESP_SLVERR   2'b10
`endif

/* mbt_pkg.sv */
// types of the branch, timer and port execution unit
package mbt_pkg;
	typedef enum logic [1:0] {
		MBT_ST_FIRST = 2'b00,
		MBT_ST_WORD2 = 2'b01,
		MBT_ST_WORD3 = 2'b10
	} mbt_state_t;
endpackage

/* tb.sv */
// self-checking testbench for the branch, timer and port execution unit
`timescale 1ns/1ps
`default_nettype none
`include "mbt_params.svh"
module tb;
	// arbitrary decoder contents so that every accumulator value maps to a distinct pattern
	localparam logic [127:0] SEG_MAP = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0;
	localparam int           LIMIT   = 3000;
	// test program: address in bits 22:12, instruction word in bits 8:0
	localparam logic [23:0]  PROG [60] = '{
		24'h000084, 24'h001085, 24'h002086, 24'h003087, 24'h004081, 24'h00501b, 24'h006011,
		24'h00700b, 24'h008014, 24'h00902b, 24'h00a1ff, 24'h00b015, 24'h00c02b, 24'h00d190,
		24'h010082, 24'h011194, 24'h012083, 24'h013195, 24'h014195, 24'h015107, 24'h1081a0,
		24'h1a0101, 24'h101044, 24'h016073, 24'h017105, 24'h185073, 24'h18610a, 24'h187045,
		24'h18a073, 24'h18b10d, 24'h18c044, 24'h18d044, 24'h0181ff, 24'h019054, 24'h01a055,
		24'h01b08c, 24'h01c088, 24'h01d089, 24'h01e08a, 24'h01f029, 24'h0201a2, 24'h0211a2,
		24'h022050, 24'h023001, 24'h024071, 24'h0251c0, 24'h0f0017, 24'h0f1070, 24'h0f21b0,
		24'h030001, 24'h0311d0, 24'h060005, 24'h061010, 24'h062013, 24'h063004, 24'h0641e4,
		// service routine: short call sets the routine flag, interrupt return must restore it
		24'h07010c, 24'h10c046, 24'h071005, 24'h072046};
	// fetches from the call into page two up to the return from the nested long calls
	localparam logic [10:0]  MID [14] = '{11'h015, 11'h107, 11'h108, 11'h1a0, 11'h101,
		11'h016, 11'h017, 11'h185, 11'h186, 11'h18a, 11'h18b, 11'h18d, 11'h18c, 11'h187};

	// design ports
	logic        clk, rst, ce, accWrEn, bWrEn, adStop, timerOneLoad, irqAllowFlag;
	logic        timerOneFlag, timerTwoFlag, intRequest;
	logic [8:0]  instrWord;
	logic [10:0] progAddr, intVector;
	logic [3:0]  accIn, bIn, yIn, accWrData, bWrData, timerCtlV, timerCtlW, fOut, fPins;
	logic [7:0]  wideIn, adResult, timerOneIn, timerTwoIn, timerOneData, reloadValue;
	logic [7:0]  segOut, segPins;
	logic [11:0] digitOut;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	// bench state, expectations and observations
	int          seed, failures, cmp_count, cycles, stops, midEnd;
	logic        running, f1, f2, skip;
	logic [3:0]  a, b, y, fp;
	logic [7:0]  wide, adr, sp, t1, t2, t1Data;
	logic [31:0] d;
	logic [1:0]  rs;
	logic [8:0]  rom [2048];
	logic [7:0]  segAt [2048];
	logic [11:0] digAt [2048];
	logic        irqAt [2048];
	logic [10:0] trace [$];
	logic [10:0] expq [$];
	logic [3:0]  accQ [$];
	logic [3:0]  bQ [$];

	mbt_exec_unit #(.SEG_TABLE(SEG_MAP)) i_mbt_exec_unit (
		.clk, .rst, .ce, .progAddr, .instrWord, .accIn, .bIn, .yIn, .wideIn,
		.accWrEn, .accWrData, .bWrEn, .bWrData, .adResult, .adStop,
		.timerOneIn, .timerTwoIn, .timerOneFlag, .timerTwoFlag, .timerOneLoad,
		.timerOneData, .reloadValue, .timerCtlV, .timerCtlW, .intRequest, .intVector,
		.irqAllowFlag, .digitOut, .segOut, .fOut, .segPins, .fPins,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	// program memory answers in the same cycle, as the fetch port expects
	assign instrWord = rom[progAddr];

	// 10 mhz clock
	always #50 clk = ~clk;

	// record each fetch with the port state left by the previous instruction
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			report_and_stop();
		end
		if (running) begin
			trace.push_back(progAddr);
			// entry seen: withdraw the request so the service routine runs once
			if (progAddr == intVector) begin
				intRequest <= 1'b0;
			end
			segAt[progAddr] = segOut;
			digAt[progAddr] = digitOut;
			irqAt[progAddr] = irqAllowFlag;
			if (accWrEn === 1'b1) begin
				accQ.push_back(accWrData);
			end
			if (bWrEn === 1'b1) begin
				bQ.push_back(bWrData);
			end
			if (timerOneLoad === 1'b1) begin
				t1Data = timerOneData;
			end
			if (adStop === 1'b1) begin
				stops++;
			end
		end
	end

	task automatic report_and_stop();
		if (failures == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic add(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			expq.push_back(11'(i));
		end
	endtask

	task automatic check_trace(input int lo, input int hi);
		for (int i = lo; i <= hi; i++) begin
			check(32'(trace[i]), 32'(expq[i]));
		end
	endtask

	// expected fetch order; skipped words still take their cycle
	task automatic build_trace();
		expq.delete();
		add(0, 13);
		add(16, 17);
		if (f1) begin
			add(18, f2 ? 20 : 19);
		end else begin
			add(20, 20);
		end
		foreach (MID[i]) begin
			expq.push_back(MID[i]);
		end
		midEnd = expq.size();
		add(24, 32);
		if (skip) begin
			add(33, 33);
		end
		add(34, 37);
		add(192 + int'(a), 192 + int'(a));
		add(240, 242);
		add(48, 49);
		add(80 + int'(a), 80 + int'(a));
		add(96, 97);
		add(112, 112);
		add(268, 268);
		add(113, 114);
		add(97, 100);
	endtask

	// reset with fresh random operands, run the program to its final loop, then compare
	task automatic run_program();
		logic [3:0] accExp [6];
		logic [3:0] bExp [3];
		@(posedge clk);
		a = 4'($random(seed));
		b = 4'($random(seed));
		y = 4'($unsigned($random(seed)) % 12);
		fp = 4'($random(seed));
		{wide, adr, sp, t1} = $random(seed);
		{t2, f1, f2} = 10'($random(seed));
		accIn <= a;
		bIn <= b;
		yIn <= y;
		fPins <= fp;
		wideIn <= wide;
		adResult <= adr;
		segPins <= sp;
		timerOneIn <= t1;
		timerTwoIn <= t2;
		timerOneFlag <= f1;
		timerTwoFlag <= f2;
		// request stays up; only the enable near the end lets it in
		intRequest <= 1'b1;
		intVector <= 11'h070;
		rst <= 1'b1;
		running <= 1'b0;
		repeat (3) @(posedge clk);
		trace.delete();
		accQ.delete();
		bQ.delete();
		stops = 0;
		rst <= 1'b0;
		running <= 1'b1;
		while (progAddr !== 11'h064) @(posedge clk);
		repeat (2) @(posedge clk);
		skip = ~adr[y[2:0]];
		build_trace();
		check_trace(0, 13);
		check_trace(14, midEnd - 1);
		check_trace(midEnd, expq.size() - 1);
		accExp = '{sp[7:4], sp[3:0], fp, t1[3:0], a, t2[3:0]};
		bExp = '{t1[7:4], b, t2[7:4]};
		foreach (accExp[i]) check(32'(accQ[i]), 32'(accExp[i]));
		foreach (bExp[i]) check(32'(bQ[i]), 32'(bExp[i]));
		check(32'(t1Data), 32'({b, a}));
		check(32'(reloadValue), 32'({b, a}));
		check(32'({timerCtlV, timerCtlW}), 32'({a, a}));
		check(32'(fOut), 32'(a));
		check(32'(segAt[6]), 32'({b, a}));
		check(32'({segAt[7], digAt[7]}), 32'h0);
		check(32'(segAt[8]), 32'(wide));
		check(32'(segAt[241]), 32'(SEG_MAP[8 * a +: 8]));
		check(32'({digAt[9], digAt[12]}), 32'(12'h001 << y));
		check(32'({segAt[98], digAt[98]}), 32'(12'h001 << y));
		check(32'(digAt[99]), 32'h0);
		check(32'({irqAt[98], irqAllowFlag}), 32'h2);
		check(32'(stops), 32'h1);
	endtask

	// bus master: request held until its ready, response taken at the valid edge
	task automatic axi_write(input logic [3:0] ad, input logic [31:0] wd, output logic [1:0] rsp);
		logic awDone;
		logic wDone;
		awDone = 1'b0;
		wDone = 1'b0;
		@(posedge clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(awDone && wDone)) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) begin
				awDone = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready === 1'b1) begin
				wDone = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [3:0] ad, output logic [31:0] rd, output logic [1:0] rsp);
		@(posedge clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// main sequence
	initial begin
		seed = 32'hed2c;
		{failures, cmp_count, cycles, stops} = '0;
		{clk, ce, rst, running, intRequest, intVector} = 16'h6000;
		{accIn, bIn, yIn, fPins, wideIn, adResult, segPins, timerOneIn, timerTwoIn} = '0;
		{timerOneFlag, timerTwoFlag, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hf;
		foreach (rom[i]) rom[i] = 9'h000;
		// both indexed targets land in a block of same-page jumps
		for (int i = 0; i < 16; i++) begin
			rom[11'h0c0 + 11'(i)] = 9'h1f0;
			rom[11'h050 + 11'(i)] = 9'h1e0;
		end
		foreach (PROG[i]) rom[PROG[i][22:12]] = PROG[i][8:0];
		repeat (4) run_program();
		axi_read(`MBT_REG_STATUS, d, rs);
		check(d, 32'h0000_0064);
		check(32'(rs), 32'(`MBT_RESP_OKAY));
		axi_read(`MBT_REG_TIMCTL, d, rs);
		check(d, {16'h0000, b, a, a, a});
		axi_read(`MBT_REG_PORTS, d, rs);
		check(d, {a, 28'h0});
		// read-only place refuses a write
		axi_write(`MBT_REG_TIMCTL, 32'($random(seed)), rs);
		check(32'(rs), 32'(`MBT_RESP_SLVERR));
		axi_write(`MBT_REG_CTRL, 32'h1, rs);
		check(32'(rs), 32'(`MBT_RESP_OKAY));
		axi_read(`MBT_REG_CTRL, d, rs);
		check(d, 32'h1);
		report_and_stop();
	end
endmodule
`default_nettype wire
